// *** src/pcb_defs.vh ***
// constants for the pll clock buffer control block
// assumes a single 10 MHz system clock and three-level straps pre-coded
`ifndef PCB_DEFS_VH
`define PCB_DEFS_VH
// three-level strap codes (two bits per strap)
`define PCB_LVL_LOW       2'h0
`define PCB_LVL_MID       2'h1
`define PCB_LVL_HIGH      2'h2
// clock period in ns and lock timing
`define PCB_CLK_PERIOD_NS 100
`define PCB_LOCK_TIME_NS  1000
`define PCB_LOCK_CYCLES   ((`PCB_LOCK_TIME_NS + `PCB_CLK_PERIOD_NS - 1) / `PCB_CLK_PERIOD_NS)
`define PCB_LOCK_CNT_W    4
// phase offsets in time units, signed 5 bits
`define PCB_PH_W          5
// divider width
`define PCB_DIV_W         4
// bank3 invert mode outputs
`define PCB_INV_PAIR      4'ha
`define PCB_INV_ALL       4'hf
`define PCB_INV_NONE      4'h0
`endif

// *** src/pcb_bank.v ***
// one output bank: divider ratio, phase offset and disable state with
// clock-low gated entry and exit; expects decoded strap codes
`timescale 1ns/1ps
`include "pcb_defs.vh"
module pcb_bank #(
	parameter NOUT  = 4,
	parameter WIDEPH = 1
) (
	input  wire                   clk_in,
	input  wire                   srst_in,
	input  wire                   ce_in,
	input  wire [1:0]             ds1_in,
	input  wire [1:0]             ds0_in,
	input  wire [1:0]             f1_in,
	input  wire [1:0]             f0_in,
	input  wire                   dis_in,
	input  wire                   clk_lvl_in,
	output reg  [`PCB_DIV_W-1:0]  div_out,
	output reg  [`PCB_PH_W-1:0]   phase_out,
	output reg                    dis_out
);
	// ******************************
	// strap decode
	// ******************************
	function [`PCB_DIV_W-1:0] div_dec;
		input [1:0] s1;
		input [1:0] s0;
		reg   [3:0] idx;
		begin
			idx = {2'h0, s1} * 4'h3 + {2'h0, s0};
			case (idx)
				4'h0: div_dec = 4'h1;
				4'h1: div_dec = 4'h2;
				4'h2: div_dec = 4'h3;
				4'h3: div_dec = 4'h4;
				4'h4: div_dec = 4'h5;
				4'h5: div_dec = 4'h6;
				4'h6: div_dec = 4'h8;
				4'h7: div_dec = 4'ha;
				default: div_dec = 4'hc;
			endcase
		end
	endfunction
	function [`PCB_PH_W-1:0] ph_dec;
		input [1:0] s1;
		input [1:0] s0;
		input       wide;
		reg   [4:0] v;
		begin
			v = 5'h0;
			case ({s1, s0})
				4'h0: v = wide ? 5'h18 : 5'h1c;
				4'h1: v = wide ? 5'h19 : 5'h1d;
				4'h2: v = wide ? 5'h1a : 5'h1e;
				4'h4: v = wide ? 5'h1c : 5'h1f;
				4'h5: v = 5'h00;
				4'h6: v = wide ? 5'h04 : 5'h01;
				4'h8: v = wide ? 5'h06 : 5'h02;
				4'h9: v = wide ? 5'h07 : 5'h03;
				4'ha: v = wide ? 5'h08 : 5'h04;
				default: v = 5'h00;
			endcase
			ph_dec = v;
		end
	endfunction
	// ******************************
	// registers
	// ******************************
	always @(posedge clk_in) begin
		if (srst_in) begin
			div_out   <= 4'h1;
			phase_out <= 5'h0;
			dis_out   <= 1'b0;
		end else if (ce_in) begin
			div_out   <= div_dec(ds1_in, ds0_in);  // [RL11] [RL12]
			phase_out <= ph_dec(f1_in, f0_in, WIDEPH != 0);  // [RL11] [RL12]
			if (!clk_lvl_in)
				dis_out <= dis_in;  // [RL17] [RL6] [RL7]
		end
	end
endmodule

// *** src/pcb_top.v ***
// control logic of a multi-output pll clock buffer
// assumes straps are pre-coded as low/mid/high; pins are synchronised here
// Operation
// [RL1] feedback select low picks pair a
// [RL2] reference select low picks pair a
// [RL3] open two-level inputs read low
// [RL4] pll aligns feedback rising edges to reference
// [RL5] three-level straps decode low mid high
// [RL6] feedback disable drives feedback outputs disabled
// [RL7] each bank disable forces its bank
// [RL8] bank3 invert: pair, all, or none
// [RL9] lock flag high only while locked
// [RL10] mode strap: hi-z, hold low, test
// [RL11] per-bank divider and phase selects
// [RL12] feedback bank divider and three phases
// [RL13] board straps range to match frequency
// [RL14] board closes feedback loop externally
// [RL15] reference switch keeps period not short
// [RL16] four clock banks plus feedback bank
// [RL17] disable changes only at clock low
// [RL18] reference change clears lock until regained
`timescale 1ns/1ps
`include "pcb_defs.vh"
module pcb_top (
	input  wire         clk_in,
	input  wire         srst_in,
	input  wire         ce_in,
	input  wire         feedback_input_select_in,
	input  wire         reference_input_select_in,
	input  wire         reference_pair_a_in,
	input  wire         reference_pair_b_in,
	input  wire         feedback_pair_a_in,
	input  wire         feedback_pair_b_in,
	input  wire         pll_phase_ok_in,
	input  wire         out_clk_level_in,
	input  wire [1:0]   frequency_range_select_in,
	input  wire [1:0]   disabled_state_mode_in,
	input  wire [1:0]   bank3_invert_mode_in,
	input  wire [15:0]  bank_divider_select_in,
	input  wire [15:0]  bank_phase_select_in,
	input  wire [3:0]   feedback_divider_select_in,
	input  wire [1:0]   feedback_phase_select_in,
	input  wire         feedback_bank_disable_in,
	input  wire [3:0]   bank_output_disable_in,
	output reg          reference_out,
	output reg          feedback_out,
	output reg  [1:0]   frequency_range_out,
	output reg  [15:0]  bank_div_out,
	output reg  [19:0]  bank_phase_out,
	output reg  [3:0]   feedback_div_out,
	output reg  [4:0]   feedback_phase_out,
	output reg  [3:0]   bank3_invert_out,
	output reg  [4:0]   bank_out_en_n_out,
	output reg  [4:0]   bank_hold_low_out,
	output reg          factory_test_out,
	output reg          pll_acquired_flag_out
);
	// ******************************
	// synchronisers
	// ******************************
	reg  [5:0]  sync1_q;
	reg  [5:0]  sync2_q;
	wire [5:0]  pins;
	assign pins = {bank_output_disable_in, feedback_bank_disable_in, out_clk_level_in};
	reg  [1:0]  sel1_q;
	reg  [1:0]  sel2_q;
	reg         ok1_q;
	reg         ok2_q;
	// pair inputs are pins as well, so they take the same two stages
	wire [3:0]  pairs;
	assign pairs = {reference_pair_b_in, reference_pair_a_in,
		feedback_pair_b_in, feedback_pair_a_in};
	reg  [3:0]  pair1_q;
	reg  [3:0]  pair2_q;
	reg         ref_sel_prev_q;
	reg  [`PCB_LOCK_CNT_W-1:0] lock_cnt_q;
	wire [4:0]  dis_cmd;
	wire [4:0]  dis_now;
	wire [19:0] div_all;
	wire [24:0] ph_all;
	// open inputs arrive low via pull-down, so low is the idle value [RL3]
	always @(posedge clk_in) begin
		if (srst_in) begin
			sync1_q <= 6'h00;
			sync2_q <= 6'h00;
			sel1_q  <= 2'h0;
			sel2_q  <= 2'h0;
			ok1_q   <= 1'b0;
			ok2_q   <= 1'b0;
			pair1_q <= 4'h0;
			pair2_q <= 4'h0;
		end else if (ce_in) begin
			sync1_q <= pins;
			sync2_q <= sync1_q;
			sel1_q  <= {reference_input_select_in, feedback_input_select_in};
			sel2_q  <= sel1_q;
			ok1_q   <= pll_phase_ok_in;
			ok2_q   <= ok1_q;
			pair1_q <= pairs;
			pair2_q <= pair1_q;
		end
	end
	// bit 4 feedback bank, bits 3:0 clock banks
	assign dis_cmd = {sync2_q[1], sync2_q[5:2]};
	// ******************************
	// output banks
	// ******************************
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : bk
			wire [1:0] ds1;
			wire [1:0] ds0;
			wire [1:0] f1;
			wire [1:0] f0;
			if (g < 4) begin : clk_bank
				assign ds1 = bank_divider_select_in[4*g+3:4*g+2];
				assign ds0 = bank_divider_select_in[4*g+1:4*g];
				assign f1  = bank_phase_select_in[4*g+3:4*g+2];
				assign f0  = bank_phase_select_in[4*g+1:4*g];
			end else begin : fb_bank
				// feedback bank phase: only low/mid/high on one strap, mapped to end or centre
				assign ds1 = feedback_divider_select_in[3:2];
				assign ds0 = feedback_divider_select_in[1:0];
				assign f1  = feedback_phase_select_in;
				assign f0  = feedback_phase_select_in;
			end
			pcb_bank #(
				.NOUT   (g < 4 ? 4 : 2),
				.WIDEPH (g == 2 || g == 3 ? 1 : 0)
			) u_bank (
				.clk_in     (clk_in),
				.srst_in    (srst_in),
				.ce_in      (ce_in),
				.ds1_in     (ds1),
				.ds0_in     (ds0),
				.f1_in      (f1),
				.f0_in      (f0),
				.dis_in     (dis_cmd[g]),
				.clk_lvl_in (sync2_q[0]),
				.div_out    (div_all[4*g+3:4*g]),
				.phase_out  (ph_all[5*g+4:5*g]),
				.dis_out    (dis_now[g])
			);  // [RL16] [RL7] [RL6]
		end
	endgenerate
	// ******************************
	// pair selection
	// ******************************
	function pick_pair;
		input sel;
		input pair_a;
		input pair_b;
		begin
			pick_pair = sel ? pair_b : pair_a;
		end
	endfunction
	// ******************************
	// routing
	// ******************************
	always @(posedge clk_in) begin
		if (srst_in) begin
			reference_out       <= 1'b0;
			feedback_out        <= 1'b0;
			frequency_range_out <= `PCB_LVL_LOW;
			bank_div_out        <= 16'h1111;
			bank_phase_out      <= 20'h00000;
			feedback_div_out    <= 4'h1;
			feedback_phase_out  <= 5'h00;
			bank3_invert_out    <= `PCB_INV_NONE;
		end else if (ce_in) begin
			reference_out <= pick_pair(sel2_q[1], pair2_q[2], pair2_q[3]);  // [RL2]
			feedback_out  <= pick_pair(sel2_q[0], pair2_q[0], pair2_q[1]);  // [RL1] [RL4]
			frequency_range_out <= frequency_range_select_in;  // [RL5] [RL13]
			// strap outputs follow one cycle after the bank registers
			bank_div_out       <= div_all[15:0];  // [RL11]
			bank_phase_out     <= ph_all[19:0];  // [RL11]
			feedback_div_out   <= div_all[19:16];  // [RL12]
			feedback_phase_out <= ph_all[24:20];  // [RL12]
			case (bank3_invert_mode_in)
				`PCB_LVL_LOW:  bank3_invert_out <= `PCB_INV_PAIR;  // [RL8]
				`PCB_LVL_HIGH: bank3_invert_out <= `PCB_INV_ALL;  // [RL8]
				default:       bank3_invert_out <= `PCB_INV_NONE;  // [RL8]
			endcase
		end
	end
	// ******************************
	// disabled state
	// ******************************
	always @(posedge clk_in) begin
		if (srst_in) begin
			bank_out_en_n_out <= 5'h00;
			bank_hold_low_out <= 5'h00;
			factory_test_out  <= 1'b0;
		end else if (ce_in) begin
			// hi-z for high mode, hold low otherwise [RL10]
			factory_test_out <= (disabled_state_mode_in == `PCB_LVL_MID);  // [RL10]
			if (disabled_state_mode_in == `PCB_LVL_HIGH) begin
				bank_out_en_n_out <= dis_now;  // [RL10]
				bank_hold_low_out <= 5'h00;
			end else begin
				bank_out_en_n_out <= 5'h00;
				bank_hold_low_out <= dis_now;  // [RL10]
			end
		end
	end
	// ******************************
	// lock indicator
	// ******************************
	always @(posedge clk_in) begin
		if (srst_in) begin
			pll_acquired_flag_out <= 1'b0;
			ref_sel_prev_q        <= 1'b0;
			lock_cnt_q            <= {`PCB_LOCK_CNT_W{1'b0}};
		end else if (ce_in) begin
			// drop on reference change, settle count after phase ok [RL15]
			// counter stops at the settle count; flag rises one cycle after
			ref_sel_prev_q <= sel2_q[1];
			if (ref_sel_prev_q != sel2_q[1] || !ok2_q) begin
				lock_cnt_q            <= {`PCB_LOCK_CNT_W{1'b0}};
				pll_acquired_flag_out <= 1'b0;  // [RL18] [RL9]
			end else if (lock_cnt_q != `PCB_LOCK_CYCLES) begin
				lock_cnt_q            <= lock_cnt_q + 1'b1;
				pll_acquired_flag_out <= 1'b0;
			end else begin
				pll_acquired_flag_out <= 1'b1;  // [RL9]
			end
		end
	end
endmodule

// *** verif/pcb_board_model.sv ***
// board side: two reference sources, feedback trace and load clock level
// assumes clk_in is the bench clock; lock status follows lock_en_in
`timescale 1ns/1ps
module pcb_board_model (
	input  wire clk_in,
	input  wire srst_in,
	input  wire lock_en_in,
	output reg  ref_a_out,
	output reg  ref_b_out,
	output reg  fb_a_out,
	output reg  fb_b_out,
	output reg  lvl_out,
	output reg  ok_out
);
// ****************
// slow clocks so levels hold several cycles
// ****************
reg [4:0] cnt_q;
always @(posedge clk_in) begin
	cnt_q     <= srst_in ? 5'h0 : cnt_q + 5'h1;
	ref_a_out <= cnt_q[3];
	ref_b_out <= cnt_q[4];
	fb_a_out  <= ref_a_out;
	fb_b_out  <= ~cnt_q[4];
	lvl_out   <= ~cnt_q[3];
	ok_out    <= lock_en_in;
end
endmodule

// *** verif/pcb_monitor.sv ***
// checker for the clock buffer control block
// assumes straps coded low/mid/high; checks pause while ce_in is low
`timescale 1ns/1ps
module pcb_monitor (
	input wire       clk_in,
	input wire       srst_in,
	input wire       ce_in,
	input wire       feedback_input_select_in,
	input wire       reference_input_select_in,
	input wire       reference_pair_a_in,
	input wire       reference_pair_b_in,
	input wire       feedback_pair_a_in,
	input wire       feedback_pair_b_in,
	input wire       pll_phase_ok_in,
	input wire       out_clk_level_in,
	input wire [1:0] disabled_state_mode_in,
	input wire       feedback_bank_disable_in,
	input wire       reference_out,
	input wire       feedback_out,
	input wire [4:0] bank_out_en_n_out,
	input wire [4:0] bank_hold_low_out,
	input wire       factory_test_out,
	input wire       pll_acquired_flag_out
);
// ****************
// properties
// ****************
default clocking cb @(posedge clk_in); endclocking
default disable iff (srst_in || !ce_in);
wire rs = reference_input_select_in ? reference_pair_b_in : reference_pair_a_in;
wire fs = feedback_input_select_in ? feedback_pair_b_in : feedback_pair_a_in;
reg ref_sel_seen_q;
always @(posedge clk_in) ref_sel_seen_q <= reference_input_select_in;
wire lk = pll_phase_ok_in && (reference_input_select_in == ref_sel_seen_q);
chk_ref_route: assert property ((rs && $stable(reference_input_select_in))[*7] |-> reference_out)
	else $error("reference route wrong");
chk_fb_route: assert property ((!fs && $stable(feedback_input_select_in))[*7] |-> !feedback_out)
	else $error("feedback route wrong");
chk_test_mode: assert property ($stable(disabled_state_mode_in)[*4] |->
	factory_test_out == (disabled_state_mode_in == 2'h1)) else $error("test mode wrong");
chk_fb_hold: assert property ((feedback_bank_disable_in && !out_clk_level_in &&
	disabled_state_mode_in == 2'h0)[*7] |-> bank_hold_low_out[4]) else $error("fb not held");
chk_dis_edge: assert property ($past(out_clk_level_in, 3) && $past(out_clk_level_in, 4) &&
	$past(out_clk_level_in, 5) |-> $stable(bank_out_en_n_out | bank_hold_low_out))
	else $error("disable moved while clock high");
chk_lock_drop: assert property (!pll_phase_ok_in[*4] |-> !pll_acquired_flag_out)
	else $error("lock flag high while unlocked");
chk_lock_set: assert property (lk[*8] ##1 lk[*8] ##1 lk[*4] |-> pll_acquired_flag_out)
	else $error("lock flag not set");
chk_lock_ref: assert property ($changed(reference_input_select_in) |->
	##[1:6] !pll_acquired_flag_out) else $error("lock kept over reference change");
cover property ($rose(pll_acquired_flag_out));
cover property ($rose(bank_hold_low_out[4]));
cover property ($rose(factory_test_out));
endmodule
bind pcb_top pcb_monitor i_mon (.*);

// *** verif/tb.sv ***
// bench for the clock buffer control block
// assumes the board model supplies clocks, the loop and lock status
`timescale 1ns/1ps
module tb;
// ****************
// stimulus and checks
// ****************
reg clk_in = 1'b0, srst_in = 1'b1, feedback_input_select_in = 1'b0, lock_en = 1'b0;
reg reference_input_select_in = 1'b0, feedback_bank_disable_in = 1'b0, ce_in = 1'b1;
reg [1:0] frequency_range_select_in = 2'h1, disabled_state_mode_in = 2'h0;
reg [1:0] bank3_invert_mode_in = 2'h1, feedback_phase_select_in = 2'h1;
reg [15:0] bank_divider_select_in = 16'h0, bank_phase_select_in = 16'h5555;
reg [3:0] feedback_divider_select_in = 4'h0, bank_output_disable_in = 4'h0;
wire reference_pair_a_in, reference_pair_b_in, feedback_pair_a_in, feedback_pair_b_in;
wire pll_phase_ok_in, out_clk_level_in, reference_out, feedback_out, factory_test_out;
wire pll_acquired_flag_out;
wire [1:0] frequency_range_out;
wire [15:0] bank_div_out;
wire [19:0] bank_phase_out;
wire [3:0] feedback_div_out, bank3_invert_out;
wire [4:0] feedback_phase_out, bank_out_en_n_out, bank_hold_low_out;
integer seed = 88, err_count = 0, checked = 0, i, b;
reg [5:0] e;
pcb_top i_dut (.*);
pcb_board_model i_brd (.clk_in(clk_in), .srst_in(srst_in), .lock_en_in(lock_en),
	.ref_a_out(reference_pair_a_in), .ref_b_out(reference_pair_b_in),
	.fb_a_out(feedback_pair_a_in), .fb_b_out(feedback_pair_b_in),
	.lvl_out(out_clk_level_in), .ok_out(pll_phase_ok_in));
function automatic logic [1:0] r3();
	r3 = 2'({$random(seed)} % 3);
endfunction
function automatic logic [3:0] ediv(input logic [1:0] d1, input logic [1:0] d0);
	integer k;
	k = d1 * 3 + d0;
	ediv = 4'((k < 6) ? k + 1 : 2 * k - 4);
endfunction
function automatic logic [5:0] eph(input integer bk, input logic [1:0] f1, input logic [1:0] f0);
	integer v;
	v = (bk < 2) ? f1 * 3 + f0 - 4 : (f1 == 2'h1) ? 0 : (f1 == 2'h0) ? f0 - 8 : f0 + 6;
	eph = {bk > 1 && f1 == 2'h1 && f0 != 2'h1, v[4:0]};
endfunction
task chk(input [63:0] n, input [19:0] x, input [19:0] g);
	checked = checked + 1;
	if (g !== x) begin
		err_count = err_count + 1;
		$display("unexpected %0s expected %h seen %h", n, x, g);
	end
endtask
task close_out;
	$display("checks %0d mismatches %0d", checked, err_count);
	if (err_count == 0 && checked > 0)
		$display("bench passed");
	else
		$display("bench failed");
	$finish;
endtask
initial forever #50 clk_in = ~clk_in;
initial begin
	#1000000;
	err_count = err_count + 1;
	close_out;
end
initial begin
	repeat (8) @(posedge clk_in);
	srst_in <= 1'b0;
	for (i = 0; i < 24; i = i + 1) begin
		@(posedge clk_in);
		for (b = 0; b < 8; b = b + 1) begin
			bank_divider_select_in[2*b +: 2] <= (i == 0) ? 2'h2 : r3();
			bank_phase_select_in[2*b +: 2] <= (i == 0) ? 2'h2 : r3();
		end
		feedback_divider_select_in <= {r3(), r3()};
		feedback_phase_select_in <= r3();
		frequency_range_select_in <= r3();
		bank3_invert_mode_in <= 2'(i % 3);
		repeat (4) @(posedge clk_in);
		for (b = 0; b < 4; b = b + 1) begin
			chk("div", ediv(bank_divider_select_in[4*b+2 +: 2], bank_divider_select_in[4*b +: 2]),
				bank_div_out[4*b +: 4]);
			e = eph(b, bank_phase_select_in[4*b+2 +: 2], bank_phase_select_in[4*b +: 2]);
			if (!e[5]) chk("phase", e[4:0], bank_phase_out[5*b +: 5]);
		end
		chk("fbdiv", ediv(feedback_divider_select_in[3:2], feedback_divider_select_in[1:0]),
			feedback_div_out);
		chk("fbphase", feedback_phase_select_in == 2'h0 ? 5'h1c :
			(feedback_phase_select_in == 2'h2 ? 5'h04 : 5'h00), feedback_phase_out);
		chk("invert", bank3_invert_mode_in == 2'h0 ? 4'ha :
			(bank3_invert_mode_in == 2'h2 ? 4'hf : 4'h0), bank3_invert_out);
		chk("range", frequency_range_select_in, frequency_range_out);
	end
	ce_in <= 1'b0;
	bank3_invert_mode_in <= 2'h0;
	repeat (4) @(posedge clk_in);
	chk("freeze", 4'hf, bank3_invert_out);
	ce_in <= 1'b1;
	repeat (4) @(posedge clk_in);
	chk("invert", 4'ha, bank3_invert_out);
	$display("strap test done");
	for (i = 0; i < 9; i = i + 1) begin
		@(posedge clk_in);
		disabled_state_mode_in <= (i < 4) ? 2'h0 : 2'h2;
		bank_output_disable_in <= (i == 8) ? 4'h0 : 4'($random(seed));
		feedback_bank_disable_in <= (i < 8) && i[0];
		repeat (30) @(posedge clk_in);
		chk("hold", disabled_state_mode_in == 2'h0 ? {feedback_bank_disable_in,
			bank_output_disable_in} : 5'h0, bank_hold_low_out);
		chk("en_n", disabled_state_mode_in == 2'h2 ? {feedback_bank_disable_in,
			bank_output_disable_in} : 5'h0, bank_out_en_n_out);
	end
	disabled_state_mode_in <= 2'h1;
	repeat (5) @(posedge clk_in);
	chk("test", 1'b1, factory_test_out);
	disabled_state_mode_in <= 2'h0;
	lock_en <= 1'b1;
	$display("disable test done");
	repeat (30) @(posedge clk_in);
	chk("lock", 1'b1, pll_acquired_flag_out);
	reference_input_select_in <= 1'b1;
	feedback_input_select_in <= 1'b1;
	repeat (7) @(posedge clk_in);
	chk("lock", 1'b0, pll_acquired_flag_out);
	repeat (30) @(posedge clk_in);
	chk("lock", 1'b1, pll_acquired_flag_out);
	lock_en <= 1'b0;
	repeat (6) @(posedge clk_in);
	chk("lock", 1'b0, pll_acquired_flag_out);
	$display("lock test done");
	close_out;
end
endmodule
